/* hdl/ea_pkg.sv */
// Purpose: shared types, field positions and helpers for the
//          effective address unit
// Assumes: 16-bit instruction words, 24-bit addresses, 32-bit registers
// Notes:   a 24-bit extension travels as 32 bits with a zero top byte
package ea_pkg;
    localparam int ADDR_W  = 24;
    localparam int OPA_MSB = 15;
    localparam int OPA_LSB = 12;
    localparam int OPB_MSB = 11;
    localparam int OPB_LSB = 8;
    localparam int SELA_MSB = 7;
    localparam int SELA_LSB = 4;
    localparam int SELB_MSB = 3;
    localparam int SELB_LSB = 0;
    localparam int BITN_MSB = 6;
    localparam int BITN_LSB = 4;
    localparam int TRAP_MSB = 5;
    localparam int TRAP_LSB = 4;
    localparam logic [15:0] ABS8_FILL = 16'hffff;
    localparam logic [15:0] MIND_FILL = 16'h0000;
    localparam logic [3:0]  TOP_1MB   = 4'h0;
    localparam logic [31:0] STEP_B = 32'h0000_0001;
    localparam logic [31:0] STEP_W = 32'h0000_0002;
    localparam logic [31:0] STEP_L = 32'h0000_0004;

    typedef enum logic [3:0] {
        AM_REG = 4'h0, AM_IND = 4'h1, AM_DISP = 4'h2, AM_POSTINC = 4'h3,
        AM_PREDEC = 4'h4, AM_ABS = 4'h5, AM_IMM = 4'h6, AM_PCREL = 4'h7,
        AM_MEMIND = 4'h8
    } amode_t;
    typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2} opsize_t;
    typedef enum logic [1:0] {XW_8 = 2'h0, XW_16 = 2'h1,
        XW_32 = 2'h2} xwidth_t;
    typedef enum logic [2:0] {
        IC_ARITH = 3'h0, IC_MOVE = 3'h1, IC_BIT = 3'h2, IC_BRANCH = 3'h3,
        IC_JUMP = 3'h4
    } iclass_t;
    typedef enum logic [2:0] {
        BO_TEST = 3'h0, BO_SET = 3'h1, BO_CLR = 3'h2, BO_INV = 3'h3,
        BO_STORE = 3'h4, BO_ISTORE = 3'h5, BO_OTHER = 3'h6
    } bitop_t;
    typedef enum logic [2:0] {
        RP_BHI = 3'h0, RP_BLO = 3'h1, RP_WLO = 3'h2, RP_WHI = 3'h3,
        RP_LONG = 3'h4
    } reg_part_t;

    typedef struct packed {
        amode_t    mode;
        opsize_t   size;
        xwidth_t   width;
        iclass_t   iclass;
        bitop_t    bitop;
        logic      bit_from_reg;
        logic [3:0] reg_sel;
    } ea_req_t;

    typedef struct packed {
        logic [3:0] operation_field;
        logic [3:0] operation_field2;
        logic [3:0] first_register_selector;
        logic [3:0] second_register_selector;
        logic [3:0] cond;
        logic [2:0] bit_num;
        logic [1:0] trap_vec;
        logic [2:0] imp_imm;
    } fields_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [31:0] value;
        logic        wb_en;
        logic [31:0] wb_val;
        logic        illegal;
        logic        rmw;
        logic [2:0]  bit_num;
    } ea_res_t;

    function automatic logic [23:0] sext8(input logic [7:0] v);
        return {{16{v[7]}}, v};
    endfunction

    function automatic logic [23:0] sext16(input logic [15:0] v);
        return {{8{v[15]}}, v};
    endfunction

    function automatic logic [31:0] step_of(input opsize_t sz);
        case (sz)
            SZ_B:    return STEP_B;
            SZ_W:    return STEP_W;
            default: return STEP_L;
        endcase
    endfunction
endpackage

/* hdl/ea_field_split.sv */
// Purpose: split a first instruction word into its fixed fields
// Assumes: pure combinational, read by the sequencer on capture
// Notes:   implicit step code is one nibble; unknown codes give 1
module ea_field_split
    import ea_pkg::*;
(
    // first word
    input  wire logic [15:0] word_in,
    // fields
    output fields_t          fields_out
);
    always_comb begin
        fields_out = '0;
        fields_out.operation_field          = word_in[OPA_MSB:OPA_LSB];
        fields_out.operation_field2         = word_in[OPB_MSB:OPB_LSB];
        fields_out.first_register_selector  = word_in[SELA_MSB:SELA_LSB];
        fields_out.second_register_selector = word_in[SELB_MSB:SELB_LSB];
        fields_out.cond     = word_in[OPB_MSB:OPB_LSB];
        fields_out.bit_num  = word_in[BITN_MSB:BITN_LSB];
        fields_out.trap_vec = word_in[TRAP_MSB:TRAP_LSB];
        case (word_in[SELA_MSB:SELA_LSB])
            4'h8, 4'hd: fields_out.imp_imm = 3'h2;
            4'h9:       fields_out.imp_imm = 3'h4;
            default:    fields_out.imp_imm = 3'h1;
        endcase
    end
endmodule

/* hdl/ea_reg_pick.sv */
// Purpose: map a register selector and operand size to a register slot
// Assumes: eight 32-bit registers, each split into halves and bytes
// Notes:   for longwords the top selector bit is ignored
module ea_reg_pick
    import ea_pkg::*;
(
    // selector
    input  wire logic [3:0] sel_in,
    input  opsize_t         size_in,
    // slot
    output logic [2:0]      idx_out,
    output reg_part_t       part_out
);
    always_comb begin
        idx_out = sel_in[2:0];
        case (size_in)
            SZ_B:    part_out = sel_in[3] ? RP_BLO : RP_BHI;
            SZ_W:    part_out = sel_in[3] ? RP_WHI : RP_WLO;
            default: part_out = RP_LONG;
        endcase
    end
endmodule

/* hdl/ea_unit.sv */
// Purpose: instruction field split and effective address generation
// Assumes: fetch, register file and memory stage share clk_in
// Notes:   one instruction in flight; ready_out gates the first word
// How it works
// RL1: instructions arrive as whole 16-bit words
// RL2: top four bits are the operation field
// RL3: register selectors of three or four bits
// RL4: extensions 8/16/32, 24-bit with zero top
// RL5: register direct picks byte, word, longword slot
// RL6: register indirect uses low 24 register bits
// RL7: displacement added, 16-bit sign-extended, 24-bit wrap
// RL8: post-increment: use address, then add size
// RL9: pre-decrement: subtract size, write back, use
// RL10: software keeps register even for wider accesses
// RL11: 8-bit absolute gets all-ones upper bits
// RL12: 16-bit absolute sign-extends; 24-bit reaches all
// RL13: immediate operand taken from extension words; an 8-bit one from the low byte of the first word
// RL14: implicit immediates, bit number, trap vector decoded
// RL15: branch displacement sign-extended, added to PC
// RL16: PC is next instruction; limited branch reach
// RL17: software picks displacements giving even targets
// RL18: bit modify instructions do byte read-modify-write
// RL19: mode legality per instruction class
// RL20: bit operand modes and bit number source
// RL21: branch condition from dedicated condition field
// RL22: memory-indirect reads longword, drops top byte
// RL23: 1-megabyte mode clears top four address bits
// RL24: wide operands and branch targets forced even
// RL25: address arithmetic wraps silently at 24 bits
module ea_unit
    import ea_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // instruction words from fetch
    input  wire logic        word_valid_in,
    input  wire logic [15:0] word_in,
    input  ea_req_t          req_in,
    input  wire logic [23:0] pc_next_in,
    input  wire logic        mode_1mb_in,
    output logic             ready_out,
    // register file
    input  wire logic [31:0] areg_in,
    input  wire logic [7:0]  bitreg_in,
    output logic [2:0]       reg_idx_out,
    output reg_part_t        reg_part_out,
    // memory-indirect longword fetch
    output logic             mem_rd_out,
    input  wire logic        mem_data_valid_in,
    input  wire logic [31:0] mem_data_in,
    // results
    output logic             done_out,
    output fields_t          fields_out,
    output ea_res_t          result_out
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_EXT  = 4'b0010,
        ST_CALC = 4'b0100,
        ST_MIND = 4'b1000
    } state_t;

    typedef struct packed {
        state_t      state;
        ea_req_t     req;
        fields_t     fields;
        logic [15:0] word0;
        logic [23:0] pc;
        logic        mb1;
        logic [31:0] ext;
        logic [1:0]  ecnt;
        logic [2:0]  reg_idx;
        reg_part_t   reg_part;
        ea_res_t     res;
        logic        done;
        logic        mem_rd;
        logic        ready;
    } st_t;

    st_t       st_r;
    st_t       st_nxt;
    fields_t   parsed_fields;
    logic [2:0] pick_idx;
    reg_part_t pick_part;

    ea_field_split u_split (
        .word_in    (word_in),
        .fields_out (parsed_fields)
    );

    ea_reg_pick u_pick (
        .sel_in   (req_in.reg_sel),
        .size_in  (req_in.size),
        .idx_out  (pick_idx),
        .part_out (pick_part)
    );

    // extension words needed after the first word
    function automatic logic [1:0] ext_count(input amode_t m,
                                             input xwidth_t w);
        logic uses;
        uses = (m == AM_DISP) || (m == AM_ABS) || (m == AM_IMM) ||
               (m == AM_PCREL);
        if (!uses || w == XW_8)
            return 2'd0;
        return (w == XW_16) ? 2'd1 : 2'd2;
    endfunction

    // final address shaping, also reused for the memory-indirect target
    function automatic logic [23:0] shape(input logic [23:0] a,
                                          input logic even,
                                          input logic mb1);
        logic [23:0] r;
        r = a;
        if (even)
            r[0] = 1'b0;                                   // see RL24
        if (mb1)
            r[23:20] = TOP_1MB;                            // see RL23
        return r;
    endfunction

    function automatic logic mode_ok(input ea_req_t q);
        case (q.iclass)
            IC_ARITH:  return q.mode == AM_REG || q.mode == AM_IMM;
            IC_MOVE:   return q.mode != AM_PCREL && q.mode != AM_MEMIND;
            IC_BIT:    return q.mode == AM_REG || q.mode == AM_IND ||
                              (q.mode == AM_ABS && q.width == XW_8);
            IC_BRANCH: return q.mode == AM_PCREL;
            IC_JUMP:   return q.mode == AM_IND || q.mode == AM_ABS ||
                              q.mode == AM_MEMIND;
            default:   return 1'b0;
        endcase
    endfunction

    always_comb begin
        logic [23:0] ea;
        logic [31:0] step;
        logic [31:0] sum;
        logic [7:0]  b8;
        logic [15:0] e16;
        logic        even;
        logic        bit_ok;
        ea     = '0;
        step   = step_of(st_r.req.size);
        sum    = '0;
        b8     = st_r.word0[7:0];
        e16    = st_r.ext[15:0];
        even   = 1'b0;
        bit_ok = 1'b1;
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        case (st_r.state)
            ST_IDLE: begin
                if (word_valid_in) begin                   // see RL1
                    st_nxt.req      = req_in;
                    // bit modifiers always move one byte
                    if (req_in.iclass == IC_BIT)
                        st_nxt.req.size = SZ_B;            // see RL18
                    st_nxt.fields   = parsed_fields;       // see RL2
                    st_nxt.word0    = word_in;
                    st_nxt.pc       = pc_next_in;          // see RL16
                    st_nxt.mb1      = mode_1mb_in;
                    st_nxt.ext      = '0;
                    st_nxt.ecnt     = ext_count(req_in.mode, req_in.width);
                    st_nxt.reg_idx  = pick_idx;            // see RL3
                    st_nxt.reg_part = pick_part;           // see RL5
                    st_nxt.ready    = 1'b0;
                    st_nxt.res      = '0;
                    st_nxt.state    = (st_nxt.ecnt == 2'd0) ? ST_CALC
                                                            : ST_EXT;
                end
            end
            ST_EXT: begin
                if (word_valid_in) begin
                    // high word first; a 24-bit field keeps a zero top
                    st_nxt.ext  = {st_r.ext[15:0], word_in};  // see RL4
                    st_nxt.ecnt = st_r.ecnt - 2'd1;
                    if (st_r.ecnt == 2'd1)
                        st_nxt.state = ST_CALC;
                end
            end
            ST_CALC: begin
                even = st_r.req.size != SZ_B ||
                       st_r.req.mode == AM_PCREL;
                st_nxt.res.value  = '0;
                st_nxt.res.wb_en  = 1'b0;
                st_nxt.res.wb_val = '0;
                case (st_r.req.mode)
                    AM_REG: st_nxt.res.value = areg_in;
                    AM_IND: ea = areg_in[23:0];            // see RL6
                    AM_DISP: begin
                        // carry out of bit 23 is simply lost
                        if (st_r.req.width == XW_16)
                            ea = areg_in[23:0] + sext16(e16);   // see RL7
                        else
                            ea = areg_in[23:0] + st_r.ext[23:0]; // see RL25
                    end
                    AM_POSTINC: begin
                        ea  = areg_in[23:0];               // see RL8
                        sum = areg_in + step;
                        st_nxt.res.wb_en  = 1'b1;
                        st_nxt.res.wb_val = sum;
                    end
                    AM_PREDEC: begin
                        sum = areg_in - step;              // see RL9
                        ea  = sum[23:0];
                        st_nxt.res.wb_en  = 1'b1;
                        st_nxt.res.wb_val = sum;
                    end
                    AM_ABS: begin
                        case (st_r.req.width)
                            XW_8:    ea = {ABS8_FILL, b8};  // see RL11
                            XW_16:   ea = sext16(e16);      // see RL12
                            default: ea = st_r.ext[23:0];
                        endcase
                    end
                    AM_IMM: begin
                        case (st_r.req.width)              // see RL13
                            XW_8:    st_nxt.res.value = {24'h00_0000, b8};
                            XW_16:   st_nxt.res.value = {16'h0000, e16};
                            default: st_nxt.res.value = st_r.ext;
                        endcase
                    end
                    AM_PCREL: begin
                        if (st_r.req.width == XW_8)
                            ea = st_r.pc + sext8(b8);      // see RL15
                        else
                            ea = st_r.pc + sext16(e16);
                    end
                    AM_MEMIND: ea = {MIND_FILL, b8};       // see RL22
                    default: ea = '0;
                endcase
                // bit number source; stores take only the immediate form
                if (st_r.req.bit_from_reg) begin           // see RL20
                    st_nxt.res.bit_num = bitreg_in[2:0];
                    bit_ok = st_r.req.bitop != BO_STORE &&
                             st_r.req.bitop != BO_ISTORE;
                end else begin
                    st_nxt.res.bit_num = st_r.fields.bit_num;   // see RL14
                end
                st_nxt.res.illegal = !mode_ok(st_r.req) ||     // see RL19
                                     (st_r.req.iclass == IC_BIT && !bit_ok);
                st_nxt.res.rmw = st_r.req.iclass == IC_BIT &&
                                 st_r.req.bitop != BO_TEST &&
                                 st_r.req.bitop != BO_OTHER;   // see RL18
                if (st_r.req.mode == AM_MEMIND) begin
                    // pointer table sits in the low page, no shaping
                    st_nxt.res.addr = ea;
                    st_nxt.mem_rd   = 1'b1;
                    st_nxt.state    = ST_MIND;
                end else begin
                    st_nxt.res.addr = shape(ea, even, st_r.mb1);
                    st_nxt.done     = 1'b1;
                    st_nxt.ready    = 1'b1;
                    st_nxt.state    = ST_IDLE;
                end
            end
            ST_MIND: begin
                if (mem_data_valid_in) begin
                    // first byte of the pointer is discarded
                    st_nxt.res.addr = shape(mem_data_in[23:0], 1'b1,
                                            st_r.mb1);     // see RL22
                    st_nxt.mem_rd = 1'b0;
                    st_nxt.done   = 1'b1;
                    st_nxt.ready  = 1'b1;
                    st_nxt.state  = ST_IDLE;
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
                st_nxt.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r       <= '0;
            st_r.state <= ST_IDLE;
            st_r.ready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ready_out    = st_r.ready;
    assign reg_idx_out  = st_r.reg_idx;
    assign reg_part_out = st_r.reg_part;
    assign mem_rd_out   = st_r.mem_rd;
    assign done_out     = st_r.done;
    // condition nibble stays in place for the branch unit (see RL21)
    assign fields_out   = st_r.fields;
    assign result_out   = st_r.res;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_ext_word_count: assert property ( // see RL1
        st_r.state == ST_EXT && word_valid_in && st_r.ecnt == 2'd1
        |=> st_r.state == ST_CALC ##1 done_out || mem_rd_out)
        else $error("extension words not consumed one unit at a time");

    a_post_inc_wb: assert property ( // see RL8
        st_r.state == ST_CALC && st_r.req.mode == AM_POSTINC
        |=> result_out.wb_en &&
            result_out.wb_val == $past(areg_in) + step_of(st_r.req.size) &&
            result_out.addr[19:1] == $past(areg_in[19:1]))
        else $error("post-increment address or write-back wrong");

    a_pre_decr_wb: assert property ( // see RL9
        st_r.state == ST_CALC && st_r.req.mode == AM_PREDEC
        |=> result_out.wb_val == $past(areg_in) - step_of(st_r.req.size) &&
            result_out.addr[19:1] == result_out.wb_val[19:1])
        else $error("pre-decrement address or write-back wrong");

    a_abs8_fill: assert property ( // see RL11
        done_out && st_r.req.mode == AM_ABS && st_r.req.width == XW_8 &&
        !st_r.mb1 |-> result_out.addr[23:8] == ABS8_FILL)
        else $error("short absolute address upper bits not all ones");

    a_abs16_sext: assert property ( // see RL12
        done_out && st_r.req.mode == AM_ABS && st_r.req.width == XW_16 &&
        !st_r.mb1 |-> result_out.addr[23:16] == {8{result_out.addr[15]}})
        else $error("16-bit absolute address not sign-extended");

    a_small_space: assert property ( // see RL23
        done_out && st_r.mb1 |-> result_out.addr[23:20] == TOP_1MB)
        else $error("top address bits set in 1-megabyte mode");

    a_even_target: assert property ( // see RL24
        done_out && (st_r.req.size != SZ_B || st_r.req.mode == AM_PCREL ||
        st_r.req.mode == AM_MEMIND) |-> !result_out.addr[0])
        else $error("wide operand or branch target left odd");

    a_arith_modes: assert property ( // see RL19
        done_out && st_r.req.iclass == IC_ARITH &&
        !(st_r.req.mode inside {AM_REG, AM_IMM}) |-> result_out.illegal)
        else $error("arithmetic mode outside register and immediate");

    a_mind_fetch: assert property ( // see RL22
        mem_rd_out && mem_data_valid_in && !st_r.mb1
        |=> done_out && !mem_rd_out &&
            result_out.addr[23:1] == $past(mem_data_in[23:1]))
        else $error("memory-indirect target not taken from pointer");

    a_rmw_byte: assert property ( // see RL18
        done_out && result_out.rmw |-> st_r.req.size == SZ_B)
        else $error("bit modify not done as a byte access");

    c_post_inc: cover property (done_out && st_r.req.mode == AM_POSTINC);
    c_mem_ind: cover property (mem_rd_out ##[1:20] done_out);
    c_pc_rel: cover property (done_out && st_r.req.mode == AM_PCREL);
    c_illegal: cover property (done_out && result_out.illegal);
endmodule

/* sim/ea_far_model.sv */
// Purpose: register file and memory seen from the address unit
// Assumes: register i holds 00fffff0 + 2*i, pointer memory is fixed
// Notes:   read data is noise outside the answer cycle
module ea_far_model
    import ea_pkg::*;
#(
    parameter int LAT = 3
)
(
    // clock
    input  wire logic        clk_in,
    // register file
    input  wire logic [2:0]  reg_idx_in,
    output logic [31:0]      areg_out,
    output logic [7:0]       bitreg_out,
    // memory read
    input  wire logic        mem_rd_in,
    output logic             mem_data_valid_out,
    output logic [31:0]      mem_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int         wait_r = 0;
    logic [7:0] noise_r = 8'h00;
    // values kept even so wide steps stay aligned
    assign areg_out = 32'h00ff_fff0 + {28'h0, reg_idx_in, 1'b0};
    assign bitreg_out = 8'h03;
    // odd pointer so the unit has to clear bit 0 itself
    assign mem_data_out = mem_data_valid_out ? 32'hab12_3457 : {4{noise_r}};
    always @(posedge clk_in) begin
        noise_r <= noise_r + 8'h01;
        mem_data_valid_out <= 1'b0;
        if (mem_rd_in && !mem_data_valid_out) begin
            wait_r <= (wait_r == LAT) ? 0 : wait_r + 1;
            mem_data_valid_out <= (wait_r == LAT);
        end
    end
endmodule

/* sim/tb_ea_unit.sv */
// Purpose: self-checking bench of the effective address unit
// Assumes: far side model answers registers and pointer reads
// Notes:   stimulus at falling edge, back-to-back instructions
module tb_ea_unit
    import ea_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        word_valid_in = 1'b0;
    logic        mode_1mb_in = 1'b0;
    logic [15:0] word_in = 16'h0000;
    logic [23:0] pc_next_in = 24'h000000;
    logic [23:0] ptr = 24'h000000;
    ea_req_t     req_in = '0;
    logic        ready_out, mem_rd_out, mem_data_valid_in, done_out;
    logic [31:0] areg_in, mem_data_in;
    logic [7:0]  bitreg_in;
    logic [2:0]  reg_idx_out;
    reg_part_t   reg_part_out;
    fields_t     fields_out;
    ea_res_t     result_out;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;

    ea_unit DUT (.*);
    ea_far_model far (.clk_in(clk_in), .reg_idx_in(reg_idx_out),
        .areg_out(areg_in), .bitreg_out(bitreg_in), .mem_rd_in(mem_rd_out),
        .mem_data_valid_out(mem_data_valid_in), .mem_data_out(mem_data_in));

    always #50 clk_in = ~clk_in;
    always @(negedge clk_in) begin
        if (mem_rd_out === 1'b1) ptr <= result_out.addr;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            summarize;
        end
    end

    task summarize;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // one instruction: first word, nx extension words, wait for done
    task run(input ea_req_t q, input logic [15:0] w, x0, x1, input int nx);
        int i;
        i = 0;
        while (ready_out !== 1'b1 && i < 50) begin
            @(negedge clk_in);
            i++;
        end
        req_in = q;
        word_in = w;
        word_valid_in = 1'b1;
        @(negedge clk_in);
        if (nx > 0) begin
            word_in = x0;
            @(negedge clk_in);
        end
        if (nx > 1) begin
            word_in = x1;
            @(negedge clk_in);
        end
        word_valid_in = 1'b0;
        i = 0;
        while (done_out !== 1'b1 && i < 50) begin
            @(negedge clk_in);
            i++;
        end
        chk(32'(done_out), 32'h1);
    endtask

    task t_reg;
        run('{AM_REG, SZ_B, XW_8, IC_ARITH, BO_OTHER, 1'b0, 4'h9},
            16'h6a9b, 16'h0, 16'h0, 0);
        chk(32'(fields_out.operation_field), 32'h6);
        chk(32'(fields_out.first_register_selector), 32'h9);
        chk(32'(fields_out.operation_field2), 32'ha);
        chk(32'(fields_out.second_register_selector), 32'hb);
        chk(32'(reg_idx_out), 32'h1);
        chk(32'(reg_part_out), 32'(RP_BLO));
        chk(result_out.value, 32'h00ff_fff2);
        $display("register direct done");
    endtask

    task t_ind;
        run('{AM_IND, SZ_L, XW_8, IC_MOVE, BO_OTHER, 1'b0, 4'h2},
            16'h6a2b, 16'h0, 16'h0, 0);
        chk(32'(result_out.addr), 32'hff_fff4);
        chk(32'(reg_part_out), 32'(RP_LONG));
        chk(32'(result_out.illegal), 32'h0);
        run('{AM_IND, SZ_L, XW_8, IC_ARITH, BO_OTHER, 1'b0, 4'h2},
            16'h6a2b, 16'h0, 16'h0, 0);
        chk(32'(result_out.illegal), 32'h1);
        $display("register indirect done");
    endtask

    task t_disp;
        run('{AM_DISP, SZ_B, XW_16, IC_MOVE, BO_OTHER, 1'b0, 4'h2},
            16'h6e20, 16'hfff0, 16'h0, 1);
        chk(32'(result_out.addr), 32'hff_ffe4);
        run('{AM_DISP, SZ_B, XW_32, IC_MOVE, BO_OTHER, 1'b0, 4'h2},
            16'h7820, 16'h0000, 16'h0010, 2);
        chk(32'(result_out.addr), 32'h00_0004);
        $display("displacement done");
    endtask

    task t_step;
        run('{AM_POSTINC, SZ_L, XW_8, IC_MOVE, BO_OTHER, 1'b0, 4'h7},
            16'h6d70, 16'h0, 16'h0, 0);
        chk(32'(result_out.addr), 32'hff_fffe);
        chk(32'(result_out.wb_en), 32'h1);
        chk(result_out.wb_val, 32'h0100_0002);
        run('{AM_PREDEC, SZ_W, XW_8, IC_MOVE, BO_OTHER, 1'b0, 4'h1},
            16'h6d90, 16'h0, 16'h0, 0);
        chk(result_out.wb_val, 32'h00ff_fff0);
        chk(32'(result_out.addr), 32'hff_fff0);
        $display("post-increment and pre-decrement done");
    endtask

    task t_abs;
        run('{AM_ABS, SZ_B, XW_8, IC_MOVE, BO_OTHER, 1'b0, 4'h0},
            16'h5034, 16'h0, 16'h0, 0);
        chk(32'(result_out.addr), 32'hff_ff34);
        run('{AM_ABS, SZ_B, XW_16, IC_MOVE, BO_OTHER, 1'b0, 4'h0},
            16'h6a00, 16'h8000, 16'h0, 1);
        chk(32'(result_out.addr), 32'hff_8000);
        run('{AM_ABS, SZ_W, XW_32, IC_MOVE, BO_OTHER, 1'b0, 4'h0},
            16'h6b20, 16'h0012, 16'h3457, 2);
        chk(32'(result_out.addr), 32'h12_3456);
        $display("absolute done");
    endtask

    task t_imm;
        run('{AM_IMM, SZ_L, XW_32, IC_ARITH, BO_OTHER, 1'b0, 4'h0},
            16'h7a90, 16'h1234, 16'h5678, 2);
        chk(result_out.value, 32'h1234_5678);
        chk(32'(fields_out.imp_imm), 32'h4);
        chk(32'(fields_out.trap_vec), 32'h1);
        $display("immediate done");
    endtask

    task t_pc;
        pc_next_in = 24'h00_1000;
        run('{AM_PCREL, SZ_W, XW_8, IC_BRANCH, BO_OTHER, 1'b0, 4'h0},
            16'h4380, 16'h0, 16'h0, 0);
        chk(32'(result_out.addr), 32'h00_0f80);
        chk(32'(fields_out.cond), 32'h3);
        pc_next_in = 24'hff_0000;
        mode_1mb_in = 1'b1;
        run('{AM_PCREL, SZ_W, XW_8, IC_BRANCH, BO_OTHER, 1'b0, 4'h0},
            16'h4310, 16'h0, 16'h0, 0);
        mode_1mb_in = 1'b0;
        chk(32'(result_out.addr), 32'h0f_0010);
        run('{AM_PCREL, SZ_W, XW_16, IC_BRANCH, BO_OTHER, 1'b0, 4'h0},
            16'h4300, 16'h7ffe, 16'h0, 1);
        chk(32'(result_out.addr), 32'hff_7ffe);
        $display("pc relative done");
    endtask

    task t_bit;
        run('{AM_IND, SZ_B, XW_8, IC_BIT, BO_SET, 1'b0, 4'h2},
            16'h7050, 16'h0, 16'h0, 0);
        chk(32'(result_out.rmw), 32'h1);
        chk(32'(result_out.bit_num), 32'h5);
        run('{AM_IND, SZ_B, XW_8, IC_BIT, BO_TEST, 1'b1, 4'h2},
            16'h7c20, 16'h0, 16'h0, 0);
        chk(32'(result_out.bit_num), 32'h3);
        chk(32'(result_out.rmw), 32'h0);
        run('{AM_IND, SZ_B, XW_8, IC_BIT, BO_STORE, 1'b1, 4'h2},
            16'h6720, 16'h0, 16'h0, 0);
        chk(32'(result_out.illegal), 32'h1);
        $display("bit operations done");
    endtask

    task t_mind;
        run('{AM_MEMIND, SZ_L, XW_8, IC_JUMP, BO_OTHER, 1'b0, 4'h0},
            16'h5d40, 16'h0, 16'h0, 0);
        chk(32'(ptr), 32'h00_0040);
        chk(32'(result_out.addr), 32'h12_3456);
        $display("memory indirect done");
    endtask

    initial begin
        repeat (16) @(negedge clk_in);
        sys_rst_in = 1'b0;
        chk(32'(ready_out), 32'h1);
        t_reg;
        t_ind;
        t_disp;
        t_step;
        t_abs;
        t_imm;
        t_pc;
        t_bit;
        t_mind;
        summarize;
    end
endmodule
